// ---- kbd_host_pkg.sv ----
// Constants, types and decode helpers for the keyboard host mailbox port
package kbd_host_pkg;

  // ----------------------------------------------------------------
  // Host I/O ports and microcontroller locations
  // ----------------------------------------------------------------
  localparam logic [15:0] HOST_DATA_PORT = 16'h0060;
  localparam logic [15:0] HOST_CTRL_PORT = 16'h0064;
  localparam logic [15:0] MC_DATA_ADDR = 16'h7ff1;
  localparam logic [15:0] MC_STATUS_ADDR = 16'h7ff2;
  localparam logic [15:0] MC_AUX_DATA_ADDR = 16'h7ffa;
  localparam logic [15:0] MC_KBD_FLAG_ADDR = 16'h7ffd;
  localparam int SA_CD_BIT = 2;

  // ----------------------------------------------------------------
  // Status byte layout
  // ----------------------------------------------------------------
  localparam int ST_OBF_BIT = 0;
  localparam int ST_IBF_BIT = 1;
  localparam int ST_CD_BIT = 3;
  localparam int ST_AUX_BIT = 5;
  localparam logic [7:0] ST_FW_LOCKED = 8'h0b;
  localparam logic [7:0] USER_RESET = 8'h00;
  localparam logic [7:0] FLAG_REG_MASK = 8'h01;

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  localparam int IN_FIFO_DEPTH = 16;

  typedef enum logic [1:0] {PORT_NONE, PORT_DATA, PORT_CTRL} port_sel_type;

  typedef struct packed {
    logic cd;
    logic [7:0] data;
  } in_word_type;

  typedef struct packed {
    logic output_full_flag;
    logic aux_full;
    logic aux_irq;
    logic kbd_hw;
    logic kbd_fw;
    logic [7:0] user;
    logic [7:0] out_data;
    logic [7:0] last_in;
    logic cd;
    logic prev_ior_n;
    logic prev_iow_n;
    port_sel_type r_port;
    port_sel_type w_port;
    logic [7:0] w_data;
    logic [7:0] sd_o;
    logic sd_oe;
    logic [7:0] mc_rdata;
    logic keyboard_irq_line;
    logic mouse_irq_line;
    logic ibf_irq;
    logic wr_ready;
  } kbd_state_type;

  localparam kbd_state_type STATE_RESET = '{
    prev_ior_n: 1'b1, prev_iow_n: 1'b1, r_port: PORT_NONE,
    w_port: PORT_NONE, user: USER_RESET, default: '0};

  // DMA cycles carry AEN high and must never reach the ports
  function automatic port_sel_type decode_port(input logic [15:0] addr,
                                               input logic aen);
    if (aen)
      return PORT_NONE;
    else if (addr == HOST_DATA_PORT)
      return PORT_DATA;
    else if (addr == HOST_CTRL_PORT)
      return PORT_CTRL;
    else
      return PORT_NONE;
  endfunction

endpackage

// ---- kbd_in_fifo.sv ----
// Parameterised FIFO holding host-written bytes for the microcontroller
`timescale 1ns/1ps
module kbd_in_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_state_type;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("kbd_in_fifo needs a power-of-two depth of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_type st_q;
  fifo_state_type st_d;
  logic push;
  logic pop;

  assign in_ready_o = (st_q.count != (AW + 1)'(DEPTH));
  assign out_valid_o = (st_q.count != '0);
  assign out_data_o = mem[st_q.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  always_comb
  begin
    st_d = st_q;
    if (push)
      st_d.wr_ptr = st_q.wr_ptr + 1'b1;
    if (pop)
      st_d.rd_ptr = st_q.rd_ptr + 1'b1;
    if (push && !pop)
      st_d.count = st_q.count + 1'b1;
    else if (pop && !push)
      st_d.count = st_q.count - 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      st_q <= '0;
    else
      st_q <= st_d;
    if (push)
      mem[st_q.wr_ptr] <= in_data_i;
  end

endmodule

// ---- kbd_host_mailbox_port.sv ----
// Keyboard host mailbox port between an ISA host and a microcontroller
`timescale 1ns/1ps
// How it works
// - Host 0x60 write is data, read gives output byte; 0x64 cmd/status.
// - Host accesses decode only while AEN is low.
// - Host data write queues byte, command/data goes 0, input-full sets.
// - Host command write queues byte, command/data goes 1 from the 0x64 port decode.
// - Host data read clears output-full, hardware keyboard flag and aux interrupt flag.
// - Micro write 0x7FF1 loads output byte, sets output-full and kbd flag.
// - Micro write 0x7FFA loads output byte, sets output-full, aux full and aux flag; 0x7FF1 write clears aux full.
// - Micro read 0x7FF1 returns head host byte; input-full clears once the buffer empties.
// - Input-full drives an enabled micro interrupt, cleared by its read.
// - Status is host read-only; micro writes skip bits 0, 1 and 3.
// - Status: D0 output-full, D1 input-full, D3 cmd/data, D5 aux or user.
// - Keyboard line: low, hardware flag, or firmware latch by selects.
// - Firmware sets and clears its keyboard latch via bit 0 of 0x7FFD.
// - Flag register reads zeros above bit 0, bit 0 the live flag.
// - Keyboard flag resets to 0, hardware flag cleared by host data read.
// - Mouse line low or aux flag by enable; select picks D5 source.
// - Aux interrupt flag resets to 0 and clears on host data read.
module kbd_host_mailbox_port
  import kbd_host_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // ISA host side
  input wire logic [15:0] SA_I,
  input wire logic AEN_I,
  input wire logic IOR_N_I,
  input wire logic IOW_N_I,
  input wire logic [7:0] SD_I,
  output logic [7:0] SD_O,
  output logic SD_OE_O,
  output logic HOST_WR_READY_O,
  // Microcontroller side
  input wire logic [15:0] MC_ADDR_I,
  input wire logic MC_WR_I,
  input wire logic MC_RD_I,
  input wire logic [7:0] MC_WDATA_I,
  output logic [7:0] MC_RDATA_O,
  // Configuration
  input wire logic OUTPUT_IRQ_ENABLE_I,
  input wire logic KEYBOARD_IRQ_FW_SELECT_I,
  input wire logic AUX_STATUS_HW_SELECT_I,
  input wire logic INPUT_FULL_IRQ_ENABLE_I,
  // Interrupt lines
  output logic KEYBOARD_IRQ_LINE_O,
  output logic MOUSE_IRQ_LINE_O,
  output logic INPUT_FULL_INTERRUPT_O
);

  // ----------------------------------------------------------------
  // State and buffer wiring
  // ----------------------------------------------------------------
  kbd_state_type st_q;
  kbd_state_type st_d;
  in_word_type push_word;
  in_word_type head_word;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic ior_rise;
  logic iow_rise;
  logic host_data_read_end;
  logic mc_wr_data;
  logic mc_wr_aux;
  logic mc_wr_status;
  logic mc_wr_flag;
  logic mc_rd_data;
  logic input_full;
  logic kbd_flag_now;
  logic [7:0] status_byte;

  assign ior_rise = IOR_N_I && !st_q.prev_ior_n;
  assign iow_rise = IOW_N_I && !st_q.prev_iow_n;
  assign host_data_read_end = ior_rise && (st_q.r_port == PORT_DATA);
  assign mc_wr_data = MC_WR_I && (MC_ADDR_I == MC_DATA_ADDR);
  assign mc_wr_aux = MC_WR_I && (MC_ADDR_I == MC_AUX_DATA_ADDR);
  assign mc_wr_status = MC_WR_I && (MC_ADDR_I == MC_STATUS_ADDR);
  assign mc_wr_flag = MC_WR_I && (MC_ADDR_I == MC_KBD_FLAG_ADDR);
  assign mc_rd_data = MC_RD_I && (MC_ADDR_I == MC_DATA_ADDR);
  assign input_full = fifo_out_valid;

  // Bytes land on the rising edge of the write strobe, when data is settled
  assign fifo_in_valid = iow_rise && (st_q.w_port != PORT_NONE);
  assign push_word.cd = (st_q.w_port == PORT_CTRL);
  assign push_word.data = st_q.w_data;
  assign fifo_out_ready = mc_rd_data;

  kbd_in_fifo #(
    .WIDTH($bits(in_word_type)),
    .DEPTH(IN_FIFO_DEPTH)
  ) u_in_fifo (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(head_word)
  );

  // ----------------------------------------------------------------
  // Status byte and live keyboard flag
  // ----------------------------------------------------------------
  always_comb
  begin
    status_byte = st_q.user & ~ST_FW_LOCKED;
    status_byte[ST_OBF_BIT] = st_q.output_full_flag;
    status_byte[ST_IBF_BIT] = input_full;
    // Head byte decides cmd/data while pending; else the last one written
    status_byte[ST_CD_BIT] = input_full ? head_word.cd : st_q.cd;
    if (AUX_STATUS_HW_SELECT_I)
      status_byte[ST_AUX_BIT] = st_q.aux_full;
  end

  assign kbd_flag_now = KEYBOARD_IRQ_FW_SELECT_I ? st_q.kbd_fw : st_q.kbd_hw;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.prev_ior_n = IOR_N_I;
    st_d.prev_iow_n = IOW_N_I;
    st_d.wr_ready = fifo_in_ready;

    // Latch port and data while a strobe is low
    if (!IOW_N_I)
    begin
      st_d.w_port = decode_port(SA_I, AEN_I);
      st_d.w_data = SD_I;
    end
    if (!IOR_N_I)
      st_d.r_port = decode_port(SA_I, AEN_I);

    // Host read drive: output byte on 0x60, status on 0x64
    st_d.sd_oe = !IOR_N_I && (st_d.r_port != PORT_NONE);
    if (st_d.r_port == PORT_CTRL)
      st_d.sd_o = status_byte;
    else
      st_d.sd_o = st_q.out_data;

    if (fifo_in_valid && fifo_in_ready)
      st_d.cd = push_word.cd;

    // Clear first so a same-cycle micro write wins
    if (host_data_read_end)
    begin
      st_d.output_full_flag = 1'b0;
      st_d.kbd_hw = 1'b0;
      st_d.aux_irq = 1'b0;
    end
    if (mc_wr_data)
    begin
      st_d.out_data = MC_WDATA_I;
      st_d.output_full_flag = 1'b1;
      st_d.kbd_hw = 1'b1;
      st_d.aux_full = 1'b0;
    end
    if (mc_wr_aux)
    begin
      st_d.out_data = MC_WDATA_I;
      st_d.output_full_flag = 1'b1;
      st_d.aux_full = 1'b1;
      st_d.aux_irq = 1'b1;
    end
    if (mc_wr_status)
      st_d.user = MC_WDATA_I & ~ST_FW_LOCKED;
    if (mc_wr_flag)
      st_d.kbd_fw = MC_WDATA_I[0];

    // Micro read answer, one cycle after the strobe
    if (mc_rd_data)
    begin
      st_d.mc_rdata = input_full ? head_word.data
                                 : st_q.last_in;
      if (input_full)
        st_d.last_in = head_word.data;
    end
    else if (MC_RD_I && MC_ADDR_I == MC_STATUS_ADDR)
      st_d.mc_rdata = status_byte;
    else if (MC_RD_I && MC_ADDR_I == MC_KBD_FLAG_ADDR)
      st_d.mc_rdata = {7'h00, kbd_flag_now} & FLAG_REG_MASK;
    else if (MC_RD_I)
      st_d.mc_rdata = 8'h00;

    // Interrupt lines from the updated flags
    st_d.keyboard_irq_line = OUTPUT_IRQ_ENABLE_I && (KEYBOARD_IRQ_FW_SELECT_I ?
                st_d.kbd_fw : st_d.kbd_hw);
    st_d.mouse_irq_line = OUTPUT_IRQ_ENABLE_I && st_d.aux_irq;
    // Follows the pending buffer: drops for the cycle after each micro data read that no host write lands alongside
    st_d.ibf_irq = INPUT_FULL_IRQ_ENABLE_I
                   && (fifo_in_valid || (input_full && !mc_rd_data));
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESET_N_I)
      st_q <= STATE_RESET;
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Writes while full are dropped; host is expected to poll first
  assign HOST_WR_READY_O = st_q.wr_ready;
  assign SD_O = st_q.sd_o;
  assign SD_OE_O = st_q.sd_oe;
  assign MC_RDATA_O = st_q.mc_rdata;
  assign KEYBOARD_IRQ_LINE_O = st_q.keyboard_irq_line;
  assign MOUSE_IRQ_LINE_O = st_q.mouse_irq_line;
  assign INPUT_FULL_INTERRUPT_O = st_q.ibf_irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  // Read end is judged on the port latched in the last low cycle
  sequence host_data_read_s;
    !IOR_N_I ##1 (IOR_N_I && st_q.r_port == PORT_DATA && !MC_WR_I);
  endsequence

  sequence mc_data_write_s;
    MC_WR_I && MC_ADDR_I == MC_DATA_ADDR;
  endsequence

  host_read_clr_a: assert property (host_data_read_s |=>
    !st_q.output_full_flag && !st_q.kbd_hw && !st_q.aux_irq)
    else $error("host data read left a flag set");

  obf_set_a: assert property (mc_data_write_s |=>
    st_q.output_full_flag && st_q.kbd_hw && !st_q.aux_full
    && st_q.out_data == $past(MC_WDATA_I))
    else $error("micro data write did not load output");

  aux_set_a: assert property (mc_wr_aux |=>
    st_q.output_full_flag && st_q.aux_full && st_q.aux_irq)
    else $error("aux write did not set aux flags");

  aen_block_a: assert property (!IOW_N_I && AEN_I |=>
    st_q.w_port == PORT_NONE)
    else $error("write decoded during AEN");

  push_cd_a: assert property (fifo_in_valid && fifo_in_ready
    |=> input_full && st_q.cd == ($past(st_q.w_port) == PORT_CTRL))
    else $error("host write did not set input full or cmd/data");

  status_lock_a: assert property (mc_wr_status |=>
    st_q.user[ST_OBF_BIT] == 1'b0 && st_q.user[ST_CD_BIT] == 1'b0
    && st_q.user[ST_IBF_BIT] == 1'b0)
    else $error("micro status write reached a locked bit");

  keyboard_irq_line_off_a: assert property (!OUTPUT_IRQ_ENABLE_I |=>
    !KEYBOARD_IRQ_LINE_O && !MOUSE_IRQ_LINE_O)
    else $error("irq line high while disabled");

  keyboard_irq_line_fw_a: assert property (OUTPUT_IRQ_ENABLE_I
    && KEYBOARD_IRQ_FW_SELECT_I |=> KEYBOARD_IRQ_LINE_O == st_q.kbd_fw)
    else $error("keyboard line does not follow firmware latch");

  keyboard_irq_line_hw_a: assert property (OUTPUT_IRQ_ENABLE_I
    && !KEYBOARD_IRQ_FW_SELECT_I |=> KEYBOARD_IRQ_LINE_O == st_q.kbd_hw)
    else $error("keyboard line does not follow hardware flag");

  mouse_irq_line_follow_a: assert property (OUTPUT_IRQ_ENABLE_I |=>
    MOUSE_IRQ_LINE_O == st_q.aux_irq)
    else $error("mouse line does not follow aux flag");

  flag_read_a: assert property (MC_RD_I
    && MC_ADDR_I == MC_KBD_FLAG_ADDR
    |=> MC_RDATA_O[7:1] == 7'h00 && MC_RDATA_O[0] == $past(kbd_flag_now))
    else $error("flag register read wrong");

  mc_pop_a: assert property (mc_rd_data && input_full |=>
    MC_RDATA_O == $past(head_word.data))
    else $error("micro read did not return the head byte");

  ibf_irq_a: assert property (INPUT_FULL_IRQ_ENABLE_I
    && input_full && !MC_RD_I ##1 INPUT_FULL_IRQ_ENABLE_I
    |-> INPUT_FULL_INTERRUPT_O)
    else $error("input full interrupt missing");

  ibf_idle_a: assert property (!input_full && !fifo_in_valid |=>
    !INPUT_FULL_INTERRUPT_O)
    else $error("input full interrupt with nothing pending");

  data_drive_a: assert property (!IOR_N_I && !AEN_I
    && SA_I == HOST_DATA_PORT |=> SD_OE_O && SD_O == $past(st_q.out_data))
    else $error("host data read not driven with output byte");

  aen_read_a: assert property (AEN_I |=> !SD_OE_O)
    else $error("data bus driven during AEN");

endmodule

// ---- host_isa_model.sv ----
// Behavioural ISA host issuing keyboard port cycles
`timescale 1ns/1ps
module host_isa_model (
  // Clock
  input wire logic clk_i,
  // Data wire level
  input wire logic [7:0] sd_i,
  // Host cycle signals
  output logic [15:0] sa_o,
  output logic aen_o,
  output logic ior_n_o,
  output logic iow_n_o,
  output logic [7:0] sd_o
);
  initial
  begin
    sa_o = 16'h0000;
    aen_o = 1'b0;
    ior_n_o = 1'b1;
    iow_n_o = 1'b1;
    sd_o = 8'hff;
  end
  // Released data shows the inverse so stale bytes never match
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic en);
    @(posedge clk_i);
    sa_o <= a;
    aen_o <= en;
    sd_o <= d;
    iow_n_o <= 1'b0;
    @(posedge clk_i);
    iow_n_o <= 1'b1;
    aen_o <= 1'b0;
    sd_o <= ~d;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sa_o <= a;
    ior_n_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    d = sd_i;
    ior_n_o <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the keyboard host mailbox port
`timescale 1ns/1ps
module testbench;
  import kbd_host_pkg::*;
  logic clk, rst_n, mc_wr, mc_rd, oie, fws, auxs, ibie;
  logic [15:0] mc_addr, sa;
  logic [7:0] mc_wdata, v, host_sd, sd_o, mc_rdata;
  logic aen, ior_n, iow_n, sd_oe, rdy, k, m, ii;
  wire [7:0] sd_w = sd_oe ? sd_o : host_sd;
  int n_fail = 0;
  int tests_run = 0;
  kbd_host_mailbox_port u_dut (.MCLK_I(clk), .RESET_N_I(rst_n),
    .SA_I(sa), .AEN_I(aen), .IOR_N_I(ior_n), .IOW_N_I(iow_n),
    .SD_I(sd_w), .SD_O(sd_o), .SD_OE_O(sd_oe), .HOST_WR_READY_O(rdy),
    .MC_ADDR_I(mc_addr), .MC_WR_I(mc_wr), .MC_RD_I(mc_rd),
    .MC_WDATA_I(mc_wdata), .MC_RDATA_O(mc_rdata),
    .OUTPUT_IRQ_ENABLE_I(oie), .KEYBOARD_IRQ_FW_SELECT_I(fws),
    .AUX_STATUS_HW_SELECT_I(auxs), .INPUT_FULL_IRQ_ENABLE_I(ibie),
    .KEYBOARD_IRQ_LINE_O(k), .MOUSE_IRQ_LINE_O(m),
    .INPUT_FULL_INTERRUPT_O(ii));
  host_isa_model u_host (.clk_i(clk), .sd_i(sd_w), .sa_o(sa),
    .aen_o(aen), .ior_n_o(ior_n), .iow_n_o(iow_n), .sd_o(host_sd));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic mc_w(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mc_addr <= a;
    mc_wdata <= d;
    mc_wr <= 1'b1;
    @(posedge clk);
    mc_wr <= 1'b0;
  endtask
  task automatic mc_r(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    mc_addr <= a;
    mc_rd <= 1'b1;
    @(posedge clk);
    mc_rd <= 1'b0;
    @(posedge clk);
    d = mc_rdata;
  endtask
  task automatic mc_is(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    mc_r(a, d);
    check("mc read", d, e);
  endtask
  task automatic host_is(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    check("host read", d, e);
  endtask
  // Pins are looked at two edges on, past the single register stage
  task automatic pins_is(input logic [7:0] e);
    repeat (2) @(posedge clk);
    check("irq pins", {5'h00, k, m, ii}, e);
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial
  begin
    {rst_n, mc_wr, mc_rd, fws} = '0;
    {oie, ibie, auxs} = 3'b111;
    mc_addr = 16'h0000;
    mc_wdata = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    pins_is(8'h00);
    check("ready", {7'h00, rdy}, 8'h01);
    mc_is(MC_STATUS_ADDR, 8'h00);
    mc_is(MC_KBD_FLAG_ADDR, 8'h00);
    mc_is(16'h7ff0, 8'h00);
    u_host.wr(HOST_DATA_PORT, 8'ha5, 1'b0);
    host_is(HOST_CTRL_PORT, 8'h02);
    pins_is(8'h01);
    mc_is(MC_DATA_ADDR, 8'ha5);
    mc_is(MC_STATUS_ADDR, 8'h00);
    pins_is(8'h00);
    u_host.wr(HOST_CTRL_PORT, 8'h3c, 1'b0);
    mc_is(MC_STATUS_ADDR, 8'h0a);
    mc_is(MC_DATA_ADDR, 8'h3c);
    // Refused writes leave cmd/data at the last command byte
    u_host.wr(HOST_DATA_PORT, 8'h11, 1'b1);
    u_host.wr(16'h0061, 8'h22, 1'b0);
    mc_is(MC_STATUS_ADDR, 8'h08);
    mc_w(MC_DATA_ADDR, 8'h55);
    pins_is(8'h04);
    mc_is(MC_KBD_FLAG_ADDR, 8'h01);
    mc_is(MC_STATUS_ADDR, 8'h09);
    host_is(HOST_CTRL_PORT, 8'h09);
    host_is(HOST_DATA_PORT, 8'h55);
    pins_is(8'h00);
    mc_is(MC_STATUS_ADDR, 8'h08);
    mc_w(MC_AUX_DATA_ADDR, 8'h66);
    pins_is(8'h02);
    mc_is(MC_STATUS_ADDR, 8'h29);
    host_is(HOST_DATA_PORT, 8'h66);
    pins_is(8'h00);
    mc_w(MC_DATA_ADDR, 8'h77);
    mc_is(MC_STATUS_ADDR, 8'h09);
    host_is(HOST_DATA_PORT, 8'h77);
    auxs <= 1'b0;
    mc_w(MC_STATUS_ADDR, 8'hff);
    host_is(HOST_CTRL_PORT, 8'hfc);
    mc_w(MC_STATUS_ADDR, 8'h00);
    auxs <= 1'b1;
    fws <= 1'b1;
    mc_w(MC_AUX_DATA_ADDR, 8'h12);
    mc_w(MC_KBD_FLAG_ADDR, 8'h01);
    pins_is(8'h06);
    mc_is(MC_KBD_FLAG_ADDR, 8'h01);
    oie <= 1'b0;
    pins_is(8'h00);
    oie <= 1'b1;
    mc_w(MC_KBD_FLAG_ADDR, 8'h00);
    pins_is(8'h02);
    host_is(HOST_DATA_PORT, 8'h12);
    fws <= 1'b0;
    pins_is(8'h00);
    // Sixteen fill the buffer; the extra byte must be dropped
    for (int i = 0; i < 17; i++)
      u_host.wr(HOST_DATA_PORT, 8'(i), 1'b0);
    check("ready", {7'h00, rdy}, 8'h00);
    for (int i = 0; i < 16; i++)
      mc_is(MC_DATA_ADDR, 8'(i));
    mc_r(MC_STATUS_ADDR, v);
    check("input full", {7'h00, v[ST_IBF_BIT]}, 8'h00);
    pins_is(8'h00);
    check("ready", {7'h00, rdy}, 8'h01);
    stop_test();
  end
endmodule
